/* src/swsr_readout.sv */
// switch status readout with apb registers and polling
//
// Our own choices: the APB interface to the registers and the placing of the registers.
module swsr_readout
#(
  parameter int unsigned POLL_PERIOD = swsr_pkg::POLL_PERIOD_CYC
)
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire swsr_pkg::swsr_apb_req_s apb_req_i,
  input wire swsr_pkg::swsr_sense_s sense_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  output logic wetting_en_o,
  output logic irq_o
);
  import swsr_pkg::*;

  logic run;
  logic [15:0] poll_act;
  logic [9:0] comp_thr;
  logic [9:0] first_level_threshold;
  logic [9:0] second_level_threshold;
  logic [9:0] third_level_threshold;
  logic [31:0] matrix_lo;
  logic [3:0] matrix_hi;
  logic [31:0] comp_stat;
  logic [31:0] adc_input_status_second;
  logic [2:0] int_stat;
  logic [2:0] int_mask;
  logic [2:0] next_int_stat;
  logic [2:0] next_int_mask;
  logic [2:0] events;
  logic done;
  logic done_early;
  logic active;
  logic access;
  logic wr_fire;
  logic [31:0] next_rdata;
  logic next_err;
  logic [31:0] next_comp;
  logic [31:0] next_adc;
  logic [3:0][1:0] adc_code;
  logic [3:0] above;

  swsr_poll_timer #(
    .PERIOD(POLL_PERIOD)
  ) u_timer (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .run_i(run),
    .act_cyc_i(poll_act),
    .active_o(active),
    .done_o(done_early)
  );

  // latch strobe one cycle on, inside the wetting output window
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
      done <= 1'b0;
    else
      done <= done_early;
  end

  // per analog input: comparator and three-level classifier
  for (genvar g = 0; g < 4; g++)
  begin : g_in
    assign above[g] = sense_i.volt[g] > comp_thr;
    swsr_level_classify u_cls (
      .volt_i(sense_i.volt[g]),
      .first_i(first_level_threshold),
      .second_i(second_level_threshold),
      .third_i(third_level_threshold),
      .code_o(adc_code[g])
    );
  end

  assign access = apb_req_i.psel && apb_req_i.penable;
  assign wr_fire = access && pready_o && apb_req_i.pwrite;

  // apb answer one cycle into the access phase
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o <= access && !pready_o;
      if (access && !pready_o)
      begin
        prdata_o <= apb_req_i.pwrite ? 32'h0000_0000 : next_rdata;
        pslverr_o <= next_err;
      end
    end
  end

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    case (apb_req_i.paddr)
      OFS_CTRL: next_rdata[CTRL_RUN_BIT] = run;
      OFS_POLL_ACT: next_rdata[15:0] = poll_act;
      OFS_COMP_THR: next_rdata[9:0] = comp_thr;
      OFS_FIRST_THR: next_rdata[9:0] = first_level_threshold;
      OFS_SECOND_THR: next_rdata[9:0] = second_level_threshold;
      OFS_THIRD_THR: next_rdata[9:0] = third_level_threshold;
      OFS_MATRIX_LO: next_rdata = matrix_lo;
      OFS_MATRIX_HI: next_rdata[3:0] = matrix_hi;
      OFS_COMP_STAT: next_rdata = comp_stat;
      OFS_ADC_STAT: next_rdata = adc_input_status_second;
      OFS_INT_STAT: next_rdata[2:0] = int_stat;
      OFS_INT_MASK: next_rdata[2:0] = int_mask;
      default: next_err = 1'b1;
    endcase
  end

  // configuration registers
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      run <= 1'b0;
      poll_act <= RST_POLL_ACT;
      comp_thr <= RST_COMP_THR;
      first_level_threshold <= RST_FIRST_THR;
      second_level_threshold <= RST_SECOND_THR;
      third_level_threshold <= RST_THIRD_THR;
      int_mask <= 3'h0;
    end
    else if (wr_fire)
    begin
      case (apb_req_i.paddr)
        OFS_CTRL: run <= apb_req_i.pwdata[CTRL_RUN_BIT];
        OFS_POLL_ACT: poll_act <= apb_req_i.pwdata[15:0];
        OFS_COMP_THR: comp_thr <= apb_req_i.pwdata[9:0];
        OFS_FIRST_THR: first_level_threshold <= apb_req_i.pwdata[9:0];
        OFS_SECOND_THR: second_level_threshold <= apb_req_i.pwdata[9:0];
        OFS_THIRD_THR: third_level_threshold <= apb_req_i.pwdata[9:0];
        OFS_INT_MASK: int_mask <= apb_req_i.pwdata[2:0];
        default: ;
      endcase
    end
  end

  // new status words built from the current samples
  always_comb
  begin
    next_comp = 32'h0000_0000;
    next_adc = 32'h0000_0000;
    next_comp[COMP_NINETEEN_BIT] = above[0];
    next_comp[COMP_TWENTY_BIT] = above[1];
    next_adc[ADC_TWENTY_ONE_LSB +: 2] = adc_code[2];
    next_adc[ADC_TWENTY_TWO_LSB +: 2] = adc_code[3];
  end

  // status fields latch only at the end of the active window
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      matrix_lo <= RST_MATRIX_LO;
      matrix_hi <= RST_MATRIX_HI;
      comp_stat <= 32'h0000_0000;
      adc_input_status_second <= 32'h0000_0000;
    end
    else if (done)
    begin
      matrix_lo <= ~sense_i.matrix_closed[31:0];
      matrix_hi <= ~sense_i.matrix_closed[35:32];
      comp_stat <= next_comp;
      adc_input_status_second <= next_adc;
    end
  end

  // change events, set wins over write-one clear
  always_comb
  begin
    events = 3'h0;
    if (done)
    begin
      events[INT_MATRIX_BIT] = ({matrix_hi, matrix_lo} !=
        ~sense_i.matrix_closed);
      events[INT_COMP_BIT] = (comp_stat != next_comp);
      events[INT_ADC_BIT] = (adc_input_status_second != next_adc);
    end
    next_int_stat = int_stat;
    if (wr_fire && apb_req_i.paddr == OFS_INT_STAT)
      next_int_stat = int_stat & ~apb_req_i.pwdata[2:0];
    next_int_stat = next_int_stat | events;
    next_int_mask = int_mask;
    if (wr_fire && apb_req_i.paddr == OFS_INT_MASK)
      next_int_mask = apb_req_i.pwdata[2:0];
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      int_stat <= 3'h0;
      irq_o <= 1'b0;
      wetting_en_o <= 1'b0;
    end
    else
    begin
      int_stat <= next_int_stat;
      irq_o <= |(next_int_stat & next_int_mask);
      wetting_en_o <= active;
    end
  end

  // checks
  property p_matrix_open_one;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    done |=> matrix_lo == ~$past(sense_i.matrix_closed[31:0]);
  endproperty
  a_matrix_open_one: assert property (p_matrix_open_one)
    else $error("matrix low status not inverse of closed switches");

  property p_matrix_hi_open;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    done |=> matrix_hi == ~$past(sense_i.matrix_closed[35:32]);
  endproperty
  a_matrix_hi_open: assert property (p_matrix_hi_open)
    else $error("matrix high status not inverse of closed switches");

  property p_matrix_multi;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    done && (sense_i.matrix_closed[35:32] == 4'hf)
      |=> matrix_hi == 4'h0;
  endproperty
  a_matrix_multi: assert property (p_matrix_multi)
    else $error("simultaneous closures not all reported");

  property p_wet_window;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    done |-> wetting_en_o;
  endproperty
  a_wet_window: assert property (p_wet_window)
    else $error("sampling outside wetting window");

  property p_wet_after;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    done && (32'(poll_act) + 32'd1 < POLL_PERIOD) |=> !wetting_en_o;
  endproperty
  a_wet_after: assert property (p_wet_after)
    else $error("wetting current left on after sampling");

  property p_wet_idle;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    !run ##1 !run |=> !wetting_en_o;
  endproperty
  a_wet_idle: assert property (p_wet_idle)
    else $error("wetting current while not polling");

  property p_comp_above;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    done && (sense_i.volt[0] > comp_thr) |=> comp_stat[19];
  endproperty
  a_comp_above: assert property (p_comp_above)
    else $error("comparator bit low above threshold");

  property p_comp_below;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    done && (sense_i.volt[1] < comp_thr) |=> !comp_stat[20];
  endproperty
  a_comp_below: assert property (p_comp_below)
    else $error("comparator bit high below threshold");

  property p_nineteen_below;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    done && (sense_i.volt[0] <= comp_thr) |=> !comp_stat[COMP_NINETEEN_BIT];
  endproperty
  a_nineteen_below: assert property (p_nineteen_below)
    else $error("input nineteen bit high at or below threshold");

  property p_twenty_above;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    done && (sense_i.volt[1] > comp_thr) |=> comp_stat[COMP_TWENTY_BIT];
  endproperty
  a_twenty_above: assert property (p_twenty_above)
    else $error("input twenty bit low above threshold");

  property p_adc_band;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    done && (sense_i.volt[2] >= first_level_threshold) &&
      (sense_i.volt[2] < second_level_threshold) &&
      (second_level_threshold <= third_level_threshold)
      |=> adc_input_status_second[7:6] == 2'h1;
  endproperty
  a_adc_band: assert property (p_adc_band)
    else $error("adc code wrong between first and second level");

  property p_adc_top;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    done && (sense_i.volt[3] >= third_level_threshold)
      |=> adc_input_status_second[9:8] == 2'h3;
  endproperty
  a_adc_top: assert property (p_adc_top)
    else $error("input twenty-two code not at bits 8 and 9");

  property p_adc_low;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    done && (sense_i.volt[3] < first_level_threshold) &&
      (first_level_threshold <= second_level_threshold) &&
      (second_level_threshold <= third_level_threshold)
      |=> adc_input_status_second[9:8] == 2'h0;
  endproperty
  a_adc_low: assert property (p_adc_low)
    else $error("input twenty-two code not zero below first level");

  property p_separate;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    done |=> (comp_stat[18:0] == 19'h0) &&
      (adc_input_status_second[5:0] == 6'h0);
  endproperty
  a_separate: assert property (p_separate)
    else $error("status mixed between comparator and adc words");

  property p_hold;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    !done |=> $stable(matrix_lo) && $stable(comp_stat) &&
      $stable(matrix_hi) && $stable(adc_input_status_second);
  endproperty
  a_hold: assert property (p_hold)
    else $error("status changed outside end of window");

  property p_irq;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    irq_o == |(int_stat & int_mask);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt output disagrees with unmasked status");

  property p_unmapped;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    access && !pready_o && (apb_req_i.paddr > OFS_INT_MASK)
      |=> pslverr_o && (prdata_o == 32'h0000_0000);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped address not refused");

  c_multi_close: cover property (@(posedge ref_clk_i)
    done && sense_i.matrix_closed[3:0] == 4'hf);
  c_irq_rise: cover property (@(posedge ref_clk_i) $rose(irq_o));
  c_adc_mid: cover property (@(posedge ref_clk_i)
    done ##1 adc_input_status_second[9:8] == 2'h2);
  c_wet_start: cover property (@(posedge ref_clk_i) $rose(wetting_en_o));
  c_unmapped: cover property (@(posedge ref_clk_i) pready_o && pslverr_o);

endmodule : swsr_readout

/* src/swsr_pkg.sv */
// shared constants and types for the switch status readout block
package swsr_pkg;

  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned POLL_TIME_MS = 32;
  localparam int unsigned POLL_PERIOD_CYC = POLL_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned POLL_ACT_US = 64;
  localparam int unsigned POLL_ACT_CYC = POLL_ACT_US * (CLK_HZ / 1000000);

  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_POLL_ACT = 12'h004;
  localparam logic [11:0] OFS_COMP_THR = 12'h008;
  localparam logic [11:0] OFS_FIRST_THR = 12'h00c;
  localparam logic [11:0] OFS_SECOND_THR = 12'h010;
  localparam logic [11:0] OFS_THIRD_THR = 12'h014;
  localparam logic [11:0] OFS_MATRIX_LO = 12'h018;
  localparam logic [11:0] OFS_MATRIX_HI = 12'h01c;
  localparam logic [11:0] OFS_COMP_STAT = 12'h020;
  localparam logic [11:0] OFS_ADC_STAT = 12'h024;
  localparam logic [11:0] OFS_INT_STAT = 12'h028;
  localparam logic [11:0] OFS_INT_MASK = 12'h02c;

  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned COMP_NINETEEN_BIT = 19;
  localparam int unsigned COMP_TWENTY_BIT = 20;
  localparam int unsigned ADC_TWENTY_ONE_LSB = 6;
  localparam int unsigned ADC_TWENTY_TWO_LSB = 8;
  localparam int unsigned INT_MATRIX_BIT = 0;
  localparam int unsigned INT_COMP_BIT = 1;
  localparam int unsigned INT_ADC_BIT = 2;

  localparam logic [15:0] RST_POLL_ACT = 16'(POLL_ACT_CYC);
  localparam logic [9:0] RST_COMP_THR = 10'h200;
  localparam logic [9:0] RST_FIRST_THR = 10'h100;
  localparam logic [9:0] RST_SECOND_THR = 10'h200;
  localparam logic [9:0] RST_THIRD_THR = 10'h300;
  localparam logic [31:0] RST_MATRIX_LO = 32'hffff_ffff;
  localparam logic [3:0] RST_MATRIX_HI = 4'hf;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } swsr_apb_req_s;

  // volt index 0..3 are inputs nineteen to twenty-two
  typedef struct packed {
    logic [35:0] matrix_closed;
    logic [3:0][9:0] volt;
  } swsr_sense_s;

endpackage : swsr_pkg

/* src/swsr_poll_timer.sv */
// poll period counter with the active sampling window
module swsr_poll_timer
  import swsr_pkg::*;
#(
  parameter int unsigned PERIOD = POLL_PERIOD_CYC
)
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic run_i,
  input wire logic [15:0] act_cyc_i,
  output logic active_o,
  output logic done_o
);

  logic [19:0] cnt;
  logic [19:0] next_cnt;
  logic [19:0] act_eff;

  always_comb
  begin
    act_eff = (act_cyc_i == 16'h0000) ? 20'h00001 : {4'h0, act_cyc_i};
    if (!run_i || cnt == 20'(PERIOD - 1))
      next_cnt = 20'h00000;
    else
      next_cnt = cnt + 20'h00001;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      cnt <= 20'h00000;
      active_o <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      active_o <= run_i && (next_cnt < act_eff);
      done_o <= run_i && (next_cnt == act_eff - 20'h00001);
    end
  end

endmodule : swsr_poll_timer

/* src/swsr_level_classify.sv */
// places one input voltage among three thresholds
module swsr_level_classify
(
  input wire logic [9:0] volt_i,
  input wire logic [9:0] first_i,
  input wire logic [9:0] second_i,
  input wire logic [9:0] third_i,
  output logic [1:0] code_o
);

  always_comb
  begin
    if (volt_i >= third_i)
      code_o = 2'h3;
    else if (volt_i >= second_i)
      code_o = 2'h2;
    else if (volt_i >= first_i)
      code_o = 2'h1;
    else
      code_o = 2'h0;
  end

endmodule : swsr_level_classify

/* dv/swsr_host_model.sv */
// apb host model that issues register transfers
module swsr_host_model
(
  input wire logic ref_clk_i,
  input wire logic pready_i,
  output swsr_pkg::swsr_apb_req_s apb_req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import swsr_pkg::*;

  initial apb_req_o = '0;

  // setup, access held until pready, then release
  task automatic xfer(input logic wr, input logic [11:0] addr,
    input logic [31:0] data);
    @(posedge ref_clk_i);
    apb_req_o <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr,
      pwdata: data};
    @(posedge ref_clk_i);
    apb_req_o.penable <= 1'b1;
    do
      @(posedge ref_clk_i);
    while (pready_i !== 1'b1);
    apb_req_o <= '0;
  endtask : xfer
endmodule : swsr_host_model

/* dv/tb_swsr_readout.sv */
// self-checking bench for the switch status readout
module tb_swsr_readout;
  timeunit 1ns;
  timeprecision 1ps;
  import swsr_pkg::*;

  localparam int PER = 64;
  logic ref_clk_i;
  logic reset_n_i;
  swsr_apb_req_s req;
  swsr_sense_s sense;
  logic pready;
  logic pslverr;
  logic wet;
  logic irq;
  logic [31:0] prdata;
  logic [31:0] cexp;
  logic [31:0] aexp;
  logic [35:0] m;
  logic [3:0][9:0] v;
  logic [33:0] expq[$];
  logic [33:0] e;
  int n_fail;
  int checks;
  int seed;
  int wet_cnt;
  logic [11:0] ra[12] = '{OFS_CTRL, OFS_POLL_ACT, OFS_COMP_THR,
    OFS_FIRST_THR, OFS_SECOND_THR, OFS_THIRD_THR, OFS_MATRIX_LO,
    OFS_MATRIX_HI, OFS_COMP_STAT, OFS_ADC_STAT, OFS_INT_STAT, OFS_INT_MASK};
  logic [31:0] rv[12] = '{32'h0, 32'(RST_POLL_ACT), 32'(RST_COMP_THR),
    32'(RST_FIRST_THR), 32'(RST_SECOND_THR), 32'(RST_THIRD_THR),
    RST_MATRIX_LO, 32'(RST_MATRIX_HI), 32'h0, 32'h0, 32'h0, 32'h0};
  logic [3:0][9:0] vt[3] = '{{10'h300, 10'h2ff, 10'h201, 10'h200},
    {10'h100, 10'h0ff, 10'h3ff, 10'h1ff},
    {10'h200, 10'h100, 10'h000, 10'h201}};

  swsr_readout #(.POLL_PERIOD(PER)) dut (.ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i), .apb_req_i(req), .sense_i(sense),
    .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
    .wetting_en_o(wet), .irq_o(irq));

  swsr_host_model host (.ref_clk_i(ref_clk_i), .pready_i(pready),
    .apb_req_o(req));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  task automatic rd(input logic [11:0] a, input logic [31:0] x,
    input logic err = 1'b0);
    expq.push_back({1'b1, err, x});
    host.xfer(1'b0, a, 32'h0);
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
    input logic err = 1'b0);
    expq.push_back({1'b0, err, 32'h0});
    host.xfer(1'b1, a, d);
  endtask : wr

  function automatic logic [1:0] lvl(input logic [9:0] x);
    return x >= RST_THIRD_THR ? 2'h3 : x >= RST_SECOND_THR ? 2'h2 :
      x >= RST_FIRST_THR ? 2'h1 : 2'h0;
  endfunction : lvl

  // result monitor takes the oldest note
  always @(posedge ref_clk_i)
  begin
    if (pready === 1'b1)
    begin
      if (expq.size() == 0)
        chk("unexpected pready", 32'h1, 32'h0);
      else
      begin
        e = expq.pop_front();
        chk("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
        if (e[33])
          chk("prdata", prdata, e[31:0]);
      end
    end
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    n_fail++;
    close_out();
  end

  initial
  begin
    seed = 52;
    n_fail = 0;
    checks = 0;
    reset_n_i = 1'b0;
    sense = '0;
    repeat (6) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 12; i++)
      rd(ra[i], rv[i]);
    rd(12'h030, 32'h0, 1'b1);
    wr(12'h030, 32'h5, 1'b1);
    wr(OFS_POLL_ACT, 32'h8);
    wr(OFS_INT_MASK, 32'h7);
    wr(OFS_CTRL, 32'h1);
    for (int i = 0; i < 5; i++)
    begin
      m = 36'({$random(seed), $random(seed)});
      if (i == 1)
        m = 36'hf_ffff_ffff;
      v = (i < 3) ? vt[i] : 40'({$random(seed), $random(seed)});
      @(posedge ref_clk_i);
      sense <= '{matrix_closed: m, volt: v};
      repeat (2 * PER + 10) @(posedge ref_clk_i);
      cexp = 32'h0;
      cexp[COMP_NINETEEN_BIT] = v[0] > RST_COMP_THR;
      cexp[COMP_TWENTY_BIT] = v[1] > RST_COMP_THR;
      aexp = {22'h0, lvl(v[3]), lvl(v[2]), 6'h0};
      rd(OFS_MATRIX_LO, ~m[31:0]);
      rd(OFS_MATRIX_HI, {28'h0, ~m[35:32]});
      rd(OFS_COMP_STAT, cexp);
      rd(OFS_ADC_STAT, aexp);
    end
    wet_cnt = 0;
    repeat (2 * PER)
    begin
      @(posedge ref_clk_i);
      if (wet === 1'b1)
        wet_cnt++;
    end
    chk("wetting cycles", wet_cnt, 32'd16);
    chk("irq raised", {31'h0, irq}, 32'h1);
    wr(OFS_CTRL, 32'h0);
    repeat (3) @(posedge ref_clk_i);
    sense <= '{matrix_closed: ~m, volt: ~v};
    repeat (2 * PER + 10) @(posedge ref_clk_i);
    rd(OFS_MATRIX_LO, ~m[31:0]);
    rd(OFS_ADC_STAT, aexp);
    wr(OFS_COMP_STAT, 32'hffff_ffff);
    rd(OFS_COMP_STAT, cexp);
    for (int i = 2; i < 6; i++)
    begin
      wr(ra[i], 32'h155 + i);
      rd(ra[i], 32'h155 + i);
    end
    wr(OFS_INT_MASK, 32'h0);
    repeat (3) @(posedge ref_clk_i);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(OFS_INT_MASK, 32'h7);
    repeat (3) @(posedge ref_clk_i);
    chk("irq unmasked", {31'h0, irq}, 32'h1);
    wr(OFS_INT_STAT, 32'h7);
    repeat (3) @(posedge ref_clk_i);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    rd(OFS_INT_STAT, 32'h0);
    repeat (3) @(posedge ref_clk_i);
    close_out();
  end
endmodule : tb_swsr_readout
